/* include/cwsd_pkg.sv */
// Shared constants and carrier types for the core word select decoder
package cwsd_pkg;

    // Word address register spans bus address bits 13 down to 1
    localparam int ADDR_HI = 13;
    localparam int ADDR_LO = 1;

    // Field positions inside the word address register
    localparam int YDRV_LO = 1;
    localparam int YDRV_BLK = 3;
    localparam int YSW_LO = 4;
    localparam int YSW_BLK = 6;
    localparam int XDRV_LO = 7;
    localparam int XDRV_BLK = 9;
    localparam int XSW_LO = 10;
    localparam int XSW_BLK_LO = 12;

    // Decoder counts per group and outputs per decoder
    localparam int DEC_OUTS = 8;
    localparam int XSW_DECS = 4;
    localparam int XDRV_DECS = 2;
    localparam int YSW_DECS = 2;
    localparam int YDRV_DECS = 2;

    // Decoder input weights
    localparam int DEC_BLK_BIT = 3;
    localparam int DEC_RW_BIT = 2;
    localparam logic [7:0] DEC_ONE = 8'h01;
    localparam logic [7:0] DEC_NONE = 8'hFF;

    // Register port map
    localparam int REG_ADDR_W = 2;
    localparam logic [1:0] REG_CTRL = 2'h0;
    localparam logic [1:0] REG_WORD = 2'h1;
    localparam logic [1:0] REG_STATUS = 2'h2;
    localparam int CTRL_DATI_BIT = 0;
    localparam int STAT_VALID_BIT = 0;
    localparam int STAT_SWEN_BIT = 1;
    localparam int STAT_DRVEN_BIT = 2;
    localparam logic CTRL_DATI_RESET = 1'b0;

    // Bus transfer codes on the two control lines
    localparam logic [1:0] XFER_DATI = 2'h0;

    // Timing controls from the control logic
    typedef struct packed {
        logic readState;
        logic readTimingWindow;
        logic writeTimingWindow;
    } cwsd_timing_type;

    // All switch and driver selects, low means on
    typedef struct packed {
        logic [31:0] xSwitchOnN;
        logic [15:0] xDriverOnN;
        logic [15:0] ySwitchOnN;
        logic [15:0] yDriverOnN;
    } cwsd_sel_type;

    localparam cwsd_sel_type SEL_OFF = '{32'hFFFFFFFF, 16'hFFFF,
                                         16'hFFFF, 16'hFFFF};

endpackage

/* design/cwsd_line_decoder.sv */
// One-of-eight active-low line decoder with block select
`timescale 1ns/1ns
module cwsd_line_decoder (
    // Weighted code: 8 block, 4 read/write, 2 and 1 pair select
    input wire logic [3:0] code,
    // Decoded selects, the chosen one low
    output logic [7:0] selN
);

    // Block select high blanks every output
    assign selN = code[cwsd_pkg::DEC_BLK_BIT] ? cwsd_pkg::DEC_NONE
                  : ~(cwsd_pkg::DEC_ONE << code[2:0]);

endmodule

/* design/cwsd_top.sv */
// Word address register, gating and X/Y switch and driver decoding
//
// Contract
// - Thirteen-bit word address register captures bus address bits 13..1.
// - Word address register has no preset or clear; loads only on edges.
// - Address bit 1 comes from the buffered device-selector path.
// - All address flops load together on rising capture clock edge.
// - Bits 1,2,4,5,7,8,10,11 feed decoders directly, ungated.
// - Bit 6 true/complement, bits 12/13 four combos, low, need enable.
// - The six gated selects reach only switch decoders.
// - Bits 3 and 9 are ANDed with driver enable, drivers only.
// - Switch enable is read with read window, or write with write window.
// - Write state is always the complement of read state.
// - Each decoder takes weighted 4-bit code, drives one of eight low.
// - Decoder asserts nothing while its block select input is high.
// - Weight-4 input is read low: read selects 0-3, write 4-7.
// - Two low code bits pick one of four pairs in group.
// - Ten decoders: six on X axis, four on Y axis.
// - Driver decoder block select is gated by driver enable.
// - Driver enable is write window with read, or read window with write.
// - A switch or driver is on while its select is low.
// - With DATI-only option set every transfer is treated as DATI.
// - One X line and one Y line pick one of 8192 words.
//
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/1ns
module cwsd_top #(
    parameter int REG_DATA_W = 16
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Address capture from the bus receivers
    input wire logic [cwsd_pkg::ADDR_HI:2] wordAddrBus,
    input wire logic buffAddrBit1,
    input wire logic addrCaptureClk,
    // Read/write state and timing windows
    input wire cwsd_pkg::cwsd_timing_type timing,
    // Bus transfer control lines
    input wire logic [1:0] busCtrlIn,
    output logic [1:0] busCtrlOut,
    // Switch and driver selects
    output cwsd_pkg::cwsd_sel_type sel,
    output logic switchSelectEnable,
    output logic driverEnable,
    // Register port
    input wire logic [cwsd_pkg::REG_ADDR_W-1:0] regAddr,
    input wire logic [REG_DATA_W-1:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [REG_DATA_W-1:0] regRdData
);

    // Readback of the word address needs room for all thirteen bits
    generate
        if (REG_DATA_W < cwsd_pkg::ADDR_HI) begin : g_bad_width
            $error("REG_DATA_W too narrow for word address readback");
        end
    endgenerate

    // Block select: low only when the field matches and enable is high
    function automatic logic blockSelN(input logic [1:0] field,
                                       input logic [1:0] idx,
                                       input logic en);
        blockSelN = !((field == idx) && en);
    endfunction

    logic [cwsd_pkg::ADDR_HI:cwsd_pkg::ADDR_LO] wordAddr;
    logic [cwsd_pkg::ADDR_HI:cwsd_pkg::ADDR_LO] next_wordAddr;
    logic captureClkQ;
    logic addrValid;
    logic datiOption;
    wire logic captureEdge;
    wire logic writeState;
    wire logic swEn;
    wire logic drvEn;
    wire logic readN;
    wire logic [5:0] gatedSelN;
    wire logic [1:0] xDrvBlkN;
    wire logic [1:0] yDrvBlkN;
    wire logic [3:0] ySwIdx;
    wire logic [4:0] xSwIdx;
    wire logic [3:0] yDrvIdx;
    wire cwsd_pkg::cwsd_sel_type next_sel;
    wire cwsd_pkg::cwsd_sel_type decSel;
    wire logic [REG_DATA_W-1:0] rdMux;
    wire logic [1:0] next_busCtrl;

    // Capture clock arrives as a level from the control logic
    assign captureEdge = addrCaptureClk && !captureClkQ;
    assign next_wordAddr = {wordAddrBus, buffAddrBit1};

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            captureClkQ <= 1'b0;
        end else begin
            captureClkQ <= addrCaptureClk;
        end
    end

    // No reset here on purpose: the register only samples its inputs
    always_ff @(posedge ref_clk) begin
        if (captureEdge) begin
            wordAddr <= next_wordAddr;
        end
    end

    // Selects stay off until a first address has been captured
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            addrValid <= 1'b0;
        end else if (captureEdge) begin
            addrValid <= 1'b1;
        end
    end

    // Read/write state and the two enables
    assign writeState = !timing.readState;
    assign readN = !timing.readState;
    assign swEn = (timing.readState && timing.readTimingWindow)
                  || (writeState && timing.writeTimingWindow);
    assign drvEn = (timing.writeTimingWindow && timing.readState)
                   || (timing.readTimingWindow && writeState);

    // Six switch-only selects from bits 6, 12 and 13
    assign gatedSelN[0] = blockSelN({1'b0, wordAddr[cwsd_pkg::YSW_BLK]},
                                    2'h1, swEn);
    assign gatedSelN[1] = blockSelN({1'b0, wordAddr[cwsd_pkg::YSW_BLK]},
                                    2'h0, swEn);
    genvar k;
    generate
        for (k = 0; k < cwsd_pkg::XSW_DECS; k++) begin : g_combo
            assign gatedSelN[2+k] = blockSelN(
                wordAddr[cwsd_pkg::XSW_BLK_LO+:2], 2'(k), swEn);
        end
    endgenerate

    // Driver blocks: bits 3 and 9 qualified by driver enable
    generate
        for (k = 0; k < cwsd_pkg::XDRV_DECS; k++) begin : g_drvblk
            assign xDrvBlkN[k] = blockSelN(
                {1'b0, wordAddr[cwsd_pkg::XDRV_BLK]}, 2'(k), drvEn);
            assign yDrvBlkN[k] = blockSelN(
                {1'b0, wordAddr[cwsd_pkg::YDRV_BLK]}, 2'(k), drvEn);
        end
    endgenerate

    // X switch decoders: combos of bits 13/12 pick the block
    generate
        for (k = 0; k < cwsd_pkg::XSW_DECS; k++) begin : g_xsw
            cwsd_line_decoder u_dec (
                .code({gatedSelN[2+k], readN,
                       wordAddr[cwsd_pkg::XSW_LO+:2]}),
                .selN(decSel.xSwitchOnN[k*cwsd_pkg::DEC_OUTS+:8])
            );
        end
    endgenerate

    // X driver decoders
    generate
        for (k = 0; k < cwsd_pkg::XDRV_DECS; k++) begin : g_xdrv
            cwsd_line_decoder u_dec (
                .code({xDrvBlkN[k], readN,
                       wordAddr[cwsd_pkg::XDRV_LO+:2]}),
                .selN(decSel.xDriverOnN[k*cwsd_pkg::DEC_OUTS+:8])
            );
        end
    endgenerate

    // Y switch decoders: bit 6 true picks the upper block
    generate
        for (k = 0; k < cwsd_pkg::YSW_DECS; k++) begin : g_ysw
            cwsd_line_decoder u_dec (
                .code({gatedSelN[1-k], readN,
                       wordAddr[cwsd_pkg::YSW_LO+:2]}),
                .selN(decSel.ySwitchOnN[k*cwsd_pkg::DEC_OUTS+:8])
            );
        end
    endgenerate

    // Y driver decoders, ten decoders in all
    generate
        for (k = 0; k < cwsd_pkg::YDRV_DECS; k++) begin : g_ydrv
            cwsd_line_decoder u_dec (
                .code({yDrvBlkN[k], readN,
                       wordAddr[cwsd_pkg::YDRV_LO+:2]}),
                .selN(decSel.yDriverOnN[k*cwsd_pkg::DEC_OUTS+:8])
            );
        end
    endgenerate

    // Unknown address after reset would wake random drivers, so blank
    assign next_sel = addrValid ? decSel : cwsd_pkg::SEL_OFF;

    // Selects and enables leave through flops; low turns a device on
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sel <= cwsd_pkg::SEL_OFF;
            switchSelectEnable <= 1'b0;
            driverEnable <= 1'b0;
        end else begin
            sel <= next_sel;
            switchSelectEnable <= swEn;
            driverEnable <= drvEn;
        end
    end

    // Option forces every transfer to be answered as a read
    assign next_busCtrl = datiOption ? cwsd_pkg::XFER_DATI : busCtrlIn;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            busCtrlOut <= cwsd_pkg::XFER_DATI;
        end else begin
            busCtrlOut <= next_busCtrl;
        end
    end

    // Option bit defaults to removed, as in normal operation
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            datiOption <= cwsd_pkg::CTRL_DATI_RESET;
        end else if (regWrite && regAddr == cwsd_pkg::REG_CTRL) begin
            datiOption <= regWrData[cwsd_pkg::CTRL_DATI_BIT];
        end
    end

    // Read multiplexer; unmapped offsets read as zero
    assign rdMux =
        (regAddr == cwsd_pkg::REG_CTRL)
            ? REG_DATA_W'({datiOption}) :
        (regAddr == cwsd_pkg::REG_WORD)
            ? REG_DATA_W'(wordAddr) :
        (regAddr == cwsd_pkg::REG_STATUS)
            ? REG_DATA_W'({drvEn, swEn, addrValid}) :
        '0;

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            regRdData <= '0;
        end else begin
            regRdData <= regRead ? rdMux : '0;
        end
    end

    // Index of the Y switch a live decode should pick
    assign ySwIdx = {wordAddr[cwsd_pkg::YSW_BLK], readN,
                     wordAddr[cwsd_pkg::YSW_LO+:2]};
    // X switch and Y driver indices for the same kind of check
    assign xSwIdx = {wordAddr[cwsd_pkg::XSW_BLK_LO+:2], readN,
                     wordAddr[cwsd_pkg::XSW_LO+:2]};
    assign yDrvIdx = {wordAddr[cwsd_pkg::YDRV_BLK], readN,
                      wordAddr[cwsd_pkg::YDRV_LO+:2]};

    property p_capture;
        @(posedge ref_clk) disable iff (rst)
        captureEdge |=> wordAddr == $past(next_wordAddr);
    endproperty
    a_capture: assert property (p_capture)
        else $error("word address not loaded on capture edge");

    property p_hold;
        @(posedge ref_clk) disable iff (rst)
        (addrValid && !captureEdge) |=> $stable(wordAddr);
    endproperty
    a_hold: assert property (p_hold)
        else $error("word address changed without capture edge");

    property p_swen;
        @(posedge ref_clk) disable iff (rst)
        !rst |=> switchSelectEnable == ($past(timing.readState)
            ? $past(timing.readTimingWindow)
            : $past(timing.writeTimingWindow));
    endproperty
    a_swen: assert property (p_swen)
        else $error("switch select enable wrong");

    property p_drven;
        @(posedge ref_clk) disable iff (rst)
        !rst |=> driverEnable == ($past(timing.readState)
            ? $past(timing.writeTimingWindow)
            : $past(timing.readTimingWindow));
    endproperty
    a_drven: assert property (p_drven)
        else $error("driver enable wrong");

    property p_nodrv;
        @(posedge ref_clk) disable iff (rst)
        !drvEn |=> (&sel.xDriverOnN) && (&sel.yDriverOnN);
    endproperty
    a_nodrv: assert property (p_nodrv)
        else $error("driver selected without driver enable");

    property p_nosw;
        @(posedge ref_clk) disable iff (rst)
        !swEn |=> (&sel.xSwitchOnN) && (&sel.ySwitchOnN);
    endproperty
    a_nosw: assert property (p_nosw)
        else $error("switch selected without switch enable");

    property p_rwgroup;
        @(posedge ref_clk) disable iff (rst)
        timing.readState |=> (&sel.ySwitchOnN[15:12])
            && (&sel.ySwitchOnN[7:4]) && (&sel.yDriverOnN[15:12])
            && (&sel.yDriverOnN[7:4]);
    endproperty
    a_rwgroup: assert property (p_rwgroup)
        else $error("write group selected during read");

    property p_oneline;
        @(posedge ref_clk) disable iff (rst)
        $onehot0(~sel.xSwitchOnN) && $onehot0(~sel.ySwitchOnN)
            && $onehot0(~sel.xDriverOnN) && $onehot0(~sel.yDriverOnN);
    endproperty
    a_oneline: assert property (p_oneline)
        else $error("more than one line selected on an axis");

    property p_ydecode;
        @(posedge ref_clk) disable iff (rst)
        (addrValid && swEn) |=> sel.ySwitchOnN[$past(ySwIdx)] == 1'b0;
    endproperty
    a_ydecode: assert property (p_ydecode)
        else $error("wrong Y switch selected");

    property p_xdecode;
        @(posedge ref_clk) disable iff (rst)
        (addrValid && swEn) |=> sel.xSwitchOnN[$past(xSwIdx)] == 1'b0;
    endproperty
    a_xdecode: assert property (p_xdecode)
        else $error("wrong X switch selected");

    property p_ydrive;
        @(posedge ref_clk) disable iff (rst)
        (addrValid && drvEn) |=> sel.yDriverOnN[$past(yDrvIdx)] == 1'b0;
    endproperty
    a_ydrive: assert property (p_ydrive)
        else $error("wrong Y driver selected");

    property p_blank;
        @(posedge ref_clk) disable iff (rst)
        !addrValid |=> sel == cwsd_pkg::SEL_OFF;
    endproperty
    a_blank: assert property (p_blank)
        else $error("select active before first address capture");

    property p_dati;
        @(posedge ref_clk) disable iff (rst)
        datiOption |=> busCtrlOut == cwsd_pkg::XFER_DATI;
    endproperty
    a_dati: assert property (p_dati)
        else $error("transfer not forced to DATI");

endmodule

/* verif/cwsd_ctrl_model.sv */
// Control logic model: drives word address and capture clock
`timescale 1ns/1ns
module cwsd_ctrl_model (
    // Clock
    input wire logic ref_clk,
    // Address and capture toward the block
    output logic [cwsd_pkg::ADDR_HI:2] wordAddrBus,
    output logic buffAddrBit1,
    output logic addrCaptureClk
);
    // Idle bus before any transfer
    initial begin
        wordAddrBus = 12'h000;
        buffAddrBit1 = 1'b0;
        addrCaptureClk = 1'b0;
    end

    // Address held over the capture edge, then the bus is let go
    task automatic load_word(input logic [12:0] a);
        @(posedge ref_clk);
        wordAddrBus <= a[12:1];
        buffAddrBit1 <= a[0];
        addrCaptureClk <= 1'b1;
        repeat (2) @(posedge ref_clk);
        addrCaptureClk <= 1'b0;
        // Released bus shows the inverse so a stale load shows up
        wordAddrBus <= ~a[12:1];
        buffAddrBit1 <= ~a[0];
    endtask
endmodule

/* verif/test_core_word_select_decoder.sv */
// Self-checking bench for the word select decoder
`timescale 1ns/1ns
module test_core_word_select_decoder;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [cwsd_pkg::ADDR_HI:2] wordAddrBus;
    logic buffAddrBit1;
    logic addrCaptureClk;
    cwsd_pkg::cwsd_timing_type timing = 3'h0;
    logic [1:0] busCtrlIn = 2'h0;
    logic [1:0] busCtrlOut;
    cwsd_pkg::cwsd_sel_type sel;
    logic switchSelectEnable;
    logic driverEnable;
    logic [1:0] regAddr = 2'h0;
    logic [15:0] regWrData = 16'h0000;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [15:0] regRdData;
    int n_fail = 0;
    int checks_done = 0;
    int cycles = 0;

    // 125 MHz clock
    always #4 ref_clk = ~ref_clk;

    cwsd_ctrl_model ctrl_u (
        .ref_clk(ref_clk),
        .wordAddrBus(wordAddrBus),
        .buffAddrBit1(buffAddrBit1),
        .addrCaptureClk(addrCaptureClk)
    );

    cwsd_top #(.REG_DATA_W(16)) dut_u (
        .ref_clk(ref_clk), .rst(rst), .wordAddrBus(wordAddrBus),
        .buffAddrBit1(buffAddrBit1), .addrCaptureClk(addrCaptureClk),
        .timing(timing), .busCtrlIn(busCtrlIn), .busCtrlOut(busCtrlOut),
        .sel(sel), .switchSelectEnable(switchSelectEnable),
        .driverEnable(driverEnable), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
        .regRdData(regRdData)
    );

    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Hang guard, far above the few hundred cycles the tests need
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            complete_run();
        end
    end

    task automatic check(input logic [79:0] seen, input logic [79:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic reg_wr(input logic [1:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge ref_clk);
        regWrite <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic reg_rd(input logic [1:0] a, output logic [15:0] d);
        @(posedge ref_clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk);
        regRead <= 1'b0;
        #1 d = regRdData;
    endtask

    // Reference selects; write state taken as the inverse of read
    function automatic cwsd_pkg::cwsd_sel_type exp_sel(
        input logic [12:0] a, input logic rs, input logic rw,
        input logic ww);
        cwsd_pkg::cwsd_sel_type s;
        s = cwsd_pkg::SEL_OFF;
        if (rs & rw | !rs & ww) begin
            s.xSwitchOnN[{a[12:11], !rs, a[10:9]}] = 1'b0;
            s.ySwitchOnN[{a[5], !rs, a[4:3]}] = 1'b0;
        end
        if (rs & ww | !rs & rw) begin
            s.xDriverOnN[{a[8], !rs, a[7:6]}] = 1'b0;
            s.yDriverOnN[{a[2], !rs, a[1:0]}] = 1'b0;
        end
        return s;
    endfunction

    task automatic t_reset;
        logic [15:0] d;
        #1 check(sel, cwsd_pkg::SEL_OFF);
        check({driverEnable, switchSelectEnable, busCtrlOut}, 4'h0);
        reg_rd(cwsd_pkg::REG_CTRL, d);
        check(d, 16'h0000);
        $display("test reset done");
    endtask

    // Every timing combination against boundary and mixed addresses
    task automatic t_select;
        logic [12:0] addrs [6] = '{13'h0FFD, 13'h1000, 13'h0000,
                                   13'h1FFF, 13'h0A55, 13'h1249};
        logic [15:0] d;
        logic sw;
        logic dr;
        cwsd_pkg::cwsd_sel_type e;
        foreach (addrs[i]) begin
            ctrl_u.load_word(addrs[i]);
            reg_rd(cwsd_pkg::REG_WORD, d);
            check(d, {3'h0, addrs[i]});
            for (int t = 0; t < 8; t++) begin
                @(posedge ref_clk);
                timing <= t[2:0];
                repeat (3) @(posedge ref_clk);
                e = exp_sel(addrs[i], t[2], t[1], t[0]);
                #1 check(sel, e);
                check(sel.xSwitchOnN, e.xSwitchOnN);
                check(sel.yDriverOnN, e.yDriverOnN);
                sw = t[2] & t[1] | !t[2] & t[0];
                dr = t[2] & t[0] | !t[2] & t[1];
                check({driverEnable, switchSelectEnable}, {dr, sw});
                reg_rd(cwsd_pkg::REG_STATUS, d);
                check(d, {13'h0000, dr, sw, 1'b1});
            end
        end
        $display("test select done");
    endtask

    // Transfer code pass-through, forced read option, refused accesses
    task automatic t_dati;
        logic [15:0] d;
        for (int m = 0; m < 2; m++) begin
            reg_wr(cwsd_pkg::REG_CTRL, {15'h0000, m[0]});
            reg_rd(cwsd_pkg::REG_CTRL, d);
            check(d, {15'h0000, m[0]});
            for (int c = 0; c < 4; c++) begin
                @(posedge ref_clk);
                busCtrlIn <= c[1:0];
                repeat (2) @(posedge ref_clk);
                #1 check(busCtrlOut,
                         m ? cwsd_pkg::XFER_DATI : c[1:0]);
            end
        end
        reg_wr(cwsd_pkg::REG_CTRL, 16'h0000);
        reg_wr(2'h3, 16'hFFFF);
        reg_rd(2'h3, d);
        check(d, 16'h0000);
        reg_wr(cwsd_pkg::REG_WORD, 16'h0000);
        reg_rd(cwsd_pkg::REG_WORD, d);
        check(d, 16'h1249);
        $display("test dati done");
    endtask

    // Reset mid-run: option cleared, word kept, selects blank until load
    task automatic t_midreset;
        logic [15:0] d;
        reg_wr(cwsd_pkg::REG_CTRL, 16'h0001);
        @(posedge ref_clk);
        rst <= 1'b1;
        timing <= 3'h6;
        busCtrlIn <= 2'h3;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1 check(sel, cwsd_pkg::SEL_OFF);
        check(busCtrlOut, 2'h3);
        reg_rd(cwsd_pkg::REG_WORD, d);
        check(d, 16'h1249);
        reg_rd(cwsd_pkg::REG_STATUS, d);
        check(d, 16'h0002);
        ctrl_u.load_word(13'h0FFD);
        repeat (2) @(posedge ref_clk);
        #1 check(sel, exp_sel(13'h0FFD, 1'b1, 1'b1, 1'b0));
        $display("test midreset done");
    endtask

    // Main sequence
    initial begin
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        t_reset();
        t_select();
        t_dati();
        t_midreset();
        complete_run();
    end
endmodule
